// file: ies_pkg.sv
// package: register map, field layout and carrier types for the interrupt flag/enable block
package ies_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 32;
    localparam int NUM_SRC = NUM_BANKS * BANK_W;
    localparam int PRIO_PER_WORD = 8;
    localparam int PRIO_WORDS = NUM_SRC / PRIO_PER_WORD;
    localparam int PRIO_NIB = 4;

    // byte addresses on the apb bus
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_RELOAD = 12'h008;
    localparam logic [11:0] ADDR_FLAG_BASE = 12'h040;
    localparam logic [11:0] ADDR_EN_BASE = 12'h060;
    localparam logic [11:0] ADDR_PRIO_BASE = 12'h100;
    localparam logic [11:0] ADDR_FLAG_END = 12'h060;
    localparam logic [11:0] ADDR_EN_END = 12'h080;
    localparam logic [11:0] ADDR_PRIO_END = 12'h180;

    // control word fields
    localparam int CTRL_MULTI_VECTOR_SELECT_BIT = 12;
    localparam int CTRL_TPC_LSB = 8;
    // status word fields
    localparam int STAT_PRIO_LSB = 8;
    localparam int STAT_NUM_LSB = 0;

    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic [7:0] num;
        logic [2:0] prio;
    } ies_pres_t;

    typedef struct packed {
        logic multi_vector_select;
        logic [2:0] tpc;
    } ies_ctrl_t;
endpackage : ies_pkg

// file: ies_core.sv
// interrupt flag, enable, priority gating, status snapshot and proximity timer
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
module ies_core (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral requests
    input wire logic [ies_pkg::NUM_SRC-1:0] src_req,
    // processor core side
    input wire logic core_ack,
    input wire logic [7:0] core_ack_num,
    output ies_pkg::ies_pres_t pres,
    output logic prox_busy
);
    ies_pkg::ies_ctrl_t ctrl_r;
    logic [31:0] reload_r;
    logic [31:0] prox_cnt_r;
    logic [ies_pkg::NUM_SRC-1:0] flag_r;
    logic [ies_pkg::NUM_SRC-1:0] en_r;
    logic [2:0] prio_r [ies_pkg::NUM_SRC];
    logic [2:0] sv_prio_r;
    logic [7:0] last_num_r;
    ies_pkg::ies_pres_t pres_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic prox_busy_r;
    logic [ies_pkg::NUM_SRC-1:0] cand_w;
    logic [ies_pkg::NUM_SRC-1:0] trig_w;
    logic [ies_pkg::NUM_SRC-1:0] cand_d;

    logic acc;
    logic wr_en;
    logic [2:0] fbank;
    logic [2:0] ebank;
    logic [4:0] pword;
    logic hit_flag;
    logic hit_en;
    logic hit_prio;
    logic mapped;
    logic timer_run;
    logic prox_start;
    ies_pkg::ies_pres_t best;
    logic [31:0] rd_word;

    // answer on the second access cycle so read data comes from a flop
    assign acc = psel && penable;
    assign wr_en = acc && pready_r && pwrite && clk_en;
    assign fbank = paddr[4:2];
    assign ebank = paddr[4:2];
    assign pword = paddr[6:2];
    assign hit_flag = paddr >= ies_pkg::ADDR_FLAG_BASE && paddr < ies_pkg::ADDR_FLAG_END;
    assign hit_en = paddr >= ies_pkg::ADDR_EN_BASE && paddr < ies_pkg::ADDR_EN_END;
    assign hit_prio = paddr >= ies_pkg::ADDR_PRIO_BASE && paddr < ies_pkg::ADDR_PRIO_END;
    assign timer_run = prox_cnt_r != ies_pkg::ZERO_WORD;
    assign prox_start = |trig_w && !timer_run;

    // per-source gating and proximity qualification
    for (genvar i = 0; i < ies_pkg::NUM_SRC; i++) begin : g_src
        localparam int W = i / ies_pkg::PRIO_PER_WORD;
        localparam int L = (i % ies_pkg::PRIO_PER_WORD) * ies_pkg::PRIO_NIB;
        logic low_prio;
        assign low_prio = ctrl_r.tpc != ies_pkg::PRIO_OFF && prio_r[i] <= ctrl_r.tpc;
        // held back while the timer coalesces low-priority requests
        assign cand_w[i] = flag_r[i] && en_r[i] && prio_r[i] != ies_pkg::PRIO_OFF
            && !(timer_run && low_prio);
        assign trig_w[i] = src_req[i] && !flag_r[i] && en_r[i]
            && prio_r[i] != ies_pkg::PRIO_OFF && low_prio;

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                flag_r[i] <= 1'b0;
                en_r[i] <= 1'b0;
                prio_r[i] <= ies_pkg::PRIO_OFF;
            end else if (clk_en) begin
                // a request in the cycle software clears the bit still wins
                if (wr_en && hit_flag && fbank == 3'(i / ies_pkg::BANK_W)) begin
                    flag_r[i] <= pwdata[i % ies_pkg::BANK_W] | src_req[i];
                end else begin
                    flag_r[i] <= flag_r[i] | src_req[i];
                end
                if (wr_en && hit_en && ebank == 3'(i / ies_pkg::BANK_W)) begin
                    en_r[i] <= pwdata[i % ies_pkg::BANK_W];
                end
                if (wr_en && hit_prio && pword == 5'(W)) begin
                    prio_r[i] <= pwdata[L +: 3];
                end
            end
        end
    end

    // highest priority wins, lowest number on a tie
    always_comb begin
        best = '0;
        for (int i = 0; i < ies_pkg::NUM_SRC; i++) begin
            if (cand_w[i] && (!best.valid || prio_r[i] > best.prio)) begin
                best.valid = 1'b1;
                best.num = 8'(i);
                best.prio = prio_r[i];
            end
        end
    end

    always_comb begin
        rd_word = ies_pkg::ZERO_WORD;
        mapped = 1'b1;
        if (paddr == ies_pkg::ADDR_CTRL) begin
            rd_word[ies_pkg::CTRL_MULTI_VECTOR_SELECT_BIT] = ctrl_r.multi_vector_select;
            rd_word[ies_pkg::CTRL_TPC_LSB +: 3] = ctrl_r.tpc;
        end else if (paddr == ies_pkg::ADDR_STATUS) begin
            rd_word[ies_pkg::STAT_PRIO_LSB +: 3] = sv_prio_r;
            rd_word[ies_pkg::STAT_NUM_LSB +: 8] = last_num_r;
        end else if (paddr == ies_pkg::ADDR_RELOAD) begin
            rd_word = reload_r;
        end else if (hit_flag) begin
            rd_word = flag_r[fbank * ies_pkg::BANK_W +: ies_pkg::BANK_W];
        end else if (hit_en) begin
            rd_word = en_r[ebank * ies_pkg::BANK_W +: ies_pkg::BANK_W];
        end else if (hit_prio) begin
            for (int j = 0; j < ies_pkg::PRIO_PER_WORD; j++) begin
                rd_word[j * ies_pkg::PRIO_NIB +: 3] = prio_r[pword * ies_pkg::PRIO_PER_WORD + j];
            end
        end else begin
            mapped = 1'b0;
        end
    end

    // apb handshake and read data
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= ies_pkg::ZERO_WORD;
        end else if (clk_en) begin
            pready_r <= acc && !pready_r;
            pslverr_r <= acc && !pready_r && !mapped;
            if (acc && !pready_r && !pwrite) begin
                prdata_r <= rd_word;
            end
        end
    end

    // control and reload registers; status has no write path
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r <= '0;
            reload_r <= ies_pkg::RELOAD_RST;
        end else if (wr_en) begin
            if (paddr == ies_pkg::ADDR_CTRL) begin
                ctrl_r.multi_vector_select <= pwdata[ies_pkg::CTRL_MULTI_VECTOR_SELECT_BIT];
                ctrl_r.tpc <= pwdata[ies_pkg::CTRL_TPC_LSB +: 3];
            end else if (paddr == ies_pkg::ADDR_RELOAD) begin
                reload_r <= pwdata;
            end
        end
    end

    // proximity timer: a running count is not restarted by later triggers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prox_cnt_r <= ies_pkg::ZERO_WORD;
            prox_busy_r <= 1'b0;
        end else if (clk_en) begin
            if (prox_start) begin
                prox_cnt_r <= reload_r;
                prox_busy_r <= reload_r != ies_pkg::ZERO_WORD;
            end else if (timer_run) begin
                prox_cnt_r <= prox_cnt_r - 32'h0000_0001;
                // busy flop tracks the next count so the pin stays registered
                prox_busy_r <= prox_cnt_r != 32'h0000_0001;
            end
        end
    end

    // presentation to the core and status snapshot
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pres_r <= '0;
            sv_prio_r <= ies_pkg::PRIO_OFF;
            last_num_r <= 8'h00;
            cand_d <= '0;
        end else if (clk_en) begin
            pres_r <= best;
            cand_d <= cand_w;
            if (best.valid && !ctrl_r.multi_vector_select) begin
                sv_prio_r <= best.prio;
            end
            if (core_ack) begin
                last_num_r <= core_ack_num;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pres = pres_r;
    assign prox_busy = prox_busy_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_sv_prio;
        clk_en && best.valid && !ctrl_r.multi_vector_select |=> sv_prio_r == $past(best.prio);
    endproperty
    a_sv_prio: assert property (p_sv_prio) else $error("snapshot priority not taken");

    property p_last_num;
        clk_en && core_ack |=> last_num_r == $past(core_ack_num);
    endproperty
    a_last_num: assert property (p_last_num) else $error("serviced number not taken");

    property p_stat_hi;
        clk_en && acc && !pready_r && !pwrite && paddr == ies_pkg::ADDR_STATUS
            |=> pready_r && prdata_r[31:11] == 21'h0;
    endproperty
    a_stat_hi: assert property (p_stat_hi) else $error("status high bits not zero");

    property p_reload;
        clk_en && prox_start |=> prox_cnt_r == $past(reload_r);
    endproperty
    a_reload: assert property (p_reload) else $error("timer did not load reload");

    property p_flag_set;
        clk_en |=> (flag_r & $past(src_req)) == $past(src_req);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("request lost");

    property p_en_wr;
        wr_en && hit_en && ebank == 3'h0 |=> en_r[31:0] == $past(pwdata);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable write lost");

    property p_tpc_off;
        clk_en && ctrl_r.tpc == ies_pkg::PRIO_OFF && !timer_run |=> !timer_run;
    endproperty
    a_tpc_off: assert property (p_tpc_off) else $error("timer triggered while off");

    property p_multi_vector_select_hold;
        clk_en && ctrl_r.multi_vector_select |=> $stable(sv_prio_r);
    endproperty
    a_multi_vector_select_hold: assert property (p_multi_vector_select_hold) else $error("snapshot moved in multi mode");

    property p_prio_nz;
        pres_r.valid |-> pres_r.prio != ies_pkg::PRIO_OFF;
    endproperty
    a_prio_nz: assert property (p_prio_nz) else $error("zero priority offered");

    property p_offer_ok;
        pres_r.valid |-> cand_d[pres_r.num];
    endproperty
    a_offer_ok: assert property (p_offer_ok) else $error("ungated source offered");
endmodule : ies_core

// file: ies_core_model.sv
// processor core model: acknowledges the presented interrupt when allowed
`timescale 1ns/1ps
module ies_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control from the bench
    input wire logic ack_on,
    // interrupt controller side
    input wire ies_pkg::ies_pres_t pres,
    output logic core_ack,
    output logic [7:0] core_ack_num
);
    // ack pulses every other cycle while an offer is held, with one idle cycle between pulses
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            core_ack <= 1'b0;
            core_ack_num <= 8'h00;
        end else if (ack_on && pres.valid && !core_ack) begin
            core_ack <= 1'b1;
            core_ack_num <= pres.num;
        end else begin
            core_ack <= 1'b0;
            // the number is only valid with the pulse, so show junk otherwise
            core_ack_num <= ~core_ack_num;
        end
    end
endmodule : ies_core_model

// file: testbench.sv
// self-checking bench for the interrupt flag/enable block
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module testbench;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } ies_row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [255:0] src_req = '0;
    logic core_ack;
    logic [7:0] core_ack_num;
    logic ack_on = 1'b0;
    logic clk_en = 1'b1;
    ies_pkg::ies_pres_t pres;
    logic prox_busy;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int cmp_count = 0;
    ies_row_t rows[9] = '{
        '{12'h008, 32'hdead_beef, 32'hdead_beef, 1'b0},
        '{12'h05c, 32'ha5a5_5a5a, 32'ha5a5_5a5a, 1'b0},
        '{12'h060, 32'h8000_0001, 32'h8000_0001, 1'b0},
        '{12'h07c, 32'h1234_5678, 32'h1234_5678, 1'b0},
        '{12'h17c, 32'hffff_ffff, 32'h7777_7777, 1'b0},
        '{12'h000, 32'hffff_ffff, 32'h0000_1700, 1'b0},
        '{12'h000, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{12'h004, 32'hffff_ffff, 32'h0000_0000, 1'b0},
        '{12'hffc, 32'h0000_0001, 32'h0000_0000, 1'b1}};
    logic [11:0] rst_addr[5] = '{12'h000, 12'h004, 12'h008, 12'h040, 12'h07c};

    always #2 core_clk = ~core_clk;

    ies_core i_ies_core (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_req(src_req), .core_ack(core_ack),
        .core_ack_num(core_ack_num), .pres(pres), .prox_busy(prox_busy));
    ies_core_model i_ies_core_model (.core_clk(core_clk), .rst_n(rst_n), .ack_on(ack_on),
        .pres(pres), .core_ack(core_ack), .core_ack_num(core_ack_num));

    // apb master: one idle edge first so no signal is assigned twice in a step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic pulse(input int i);
        @(posedge core_clk);
        src_req[i] <= 1'b1;
        @(posedge core_clk);
        src_req <= '0;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    task automatic complete_run;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        complete_run;
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rst_addr[i]) begin
            xfer(1'b0, rst_addr[i], 32'h0000_0000);
            `CHK("reset value", 32'h0000_0000, rd)
        end
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].d);
            xfer(1'b0, rows[i].a, 32'h0000_0000);
            `CHK("read back", rows[i].q, rd)
            `CHK("slave error", rows[i].e, er)
        end
        // sources 5 (priority 3) and 6 (priority 0) enabled
        xfer(1'b1, 12'h060, 32'h0000_0060);
        xfer(1'b1, 12'h100, 32'h0030_0000);
        pulse(6);
        `CHK("offer prio zero", 1'b0, pres.valid)
        pulse(5);
        // valid, number 5, priority 3
        `CHK("offer", 12'h82b, pres)
        xfer(1'b0, 12'h040, 32'h0000_0000);
        `CHK("flags set", 32'h0000_0060, rd)
        xfer(1'b0, 12'h004, 32'h0000_0000);
        `CHK("status prio", 32'h0000_0300, rd)
        ack_on <= 1'b1;
        repeat (4) @(posedge core_clk);
        ack_on <= 1'b0;
        xfer(1'b0, 12'h004, 32'h0000_0000);
        `CHK("status serviced", 32'h0000_0305, rd)
        // proximity timer: reload 20, trigger level 7, source 9 priority 2 rises
        xfer(1'b1, 12'h008, 32'h0000_0014);
        xfer(1'b1, 12'h000, 32'h0000_0700);
        xfer(1'b1, 12'h104, 32'h0000_0020);
        xfer(1'b1, 12'h060, 32'h0000_0260);
        pulse(9);
        `CHK("timer running", 1'b1, prox_busy)
        `CHK("offer held", 1'b0, pres.valid)
        repeat (30) @(posedge core_clk);
        `CHK("timer expired", 1'b0, prox_busy)
        `CHK("offer released", 12'h82b, pres)
        // multi-vector mode keeps the snapshot priority still
        xfer(1'b1, 12'h000, 32'h0000_1000);
        xfer(1'b1, 12'h100, 32'h0070_0000);
        xfer(1'b0, 12'h004, 32'h0000_0000);
        `CHK("status multi", 32'h0000_0305, rd)
        xfer(1'b1, 12'h000, 32'h0000_0000);
        xfer(1'b0, 12'h004, 32'h0000_0000);
        `CHK("status single", 32'h0000_0705, rd)
        // clock enable low: a request must not reach the flags
        clk_en <= 1'b0;
        pulse(12);
        clk_en <= 1'b1;
        xfer(1'b0, 12'h040, 32'h0000_0000);
        `CHK("frozen flags", 32'h0000_0260, rd)
        // reset in mid-run clears what software wrote
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rst_addr[i]) begin
            xfer(1'b0, rst_addr[i], 32'h0000_0000);
            `CHK("mid reset value", 32'h0000_0000, rd)
        end
        `CHK("offer after reset", 1'b0, pres.valid)
        complete_run;
    end
endmodule : testbench
